// [common/gpx_params.svh]
// constants for the two-port gpio block: offsets, field positions, resets
// assumes a 32-bit axi4-lite slave with word-aligned registers
`ifndef GPX_PARAMS_SVH
`define GPX_PARAMS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define GPX_OFS_DRIVE 8'h00
`define GPX_OFS_IRQCTRL 8'h04
`define GPX_OFS_SRCSEL 8'h08
`define GPX_OFS_POLSEL 8'h0C
`define GPX_OFS_BDATA 8'h10
`define GPX_OFS_BDIR 8'h14
`define GPX_OFS_BPULL 8'h18
`define GPX_OFS_BSLEW 8'h1C
`define GPX_OFS_STATUS 8'h20
`define GPX_OFS_MASK 8'h24

// ----------------------------------------
// field positions and widths
// ----------------------------------------
`define GPX_DRIVE_W 5
`define GPX_IRQ_PINS 4
`define GPX_PORTB_W 8
`define GPX_CTRL_FLAG 3
`define GPX_CTRL_ACK 2
`define GPX_CTRL_EN 1
`define GPX_CTRL_MODE 0
`define GPX_EVT_W 1
`define GPX_EVT_PINIRQ 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define GPX_RST_BYTE 8'h00
`define GPX_RST_WORD 32'h0000_0000

`endif

// [common/gpx_pkg.sv]
// types shared by the two-port gpio block
// assumes gpx_params.svh supplies the numbers
package gpx_pkg;

	// ----------------------------------------
	// bus answer codes
	// ----------------------------------------
	typedef enum logic [1:0] {
		GPX_RESP_OKAY = 2'h0,
		GPX_RESP_SLVERR = 2'h2
	} gpx_resp_t;

	typedef logic [7:0] gpx_byte_t;
	typedef logic [31:0] gpx_word_t;

endpackage

// [rtl/gpx_sync.sv]
// two-flop synchroniser for a bus of pin levels
// assumes each bit is an independent level from outside clk_sys
`timescale 1ns/1ps
module gpx_sync #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// levels
	input wire logic [WIDTH-1:0] async,
	output logic [WIDTH-1:0] synced
);

	logic [WIDTH-1:0] stage_reg;

	// first stage is read only by the second
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			stage_reg <= '0;
			synced <= '0;
		end else begin
			stage_reg <= async;
			synced <= stage_reg;
		end
	end

endmodule

// [rtl/gpx_pin_irq.sv]
// pin interrupt detector: edge or edge-and-level, per-pin polarity
// assumes pin levels arrive already synchronised to clk_sys
`timescale 1ns/1ps
`include "gpx_params.svh"
module gpx_pin_irq #(
	parameter int PINS = `GPX_IRQ_PINS
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// synchronised pins and setup
	input wire logic [PINS-1:0] pinLevel,
	input wire logic [PINS-1:0] sourceSelect,
	input wire logic [PINS-1:0] polaritySelect,
	input wire logic detectMode,
	input wire logic ackWrite,
	// flag
	output logic pinIrqFlag,
	output logic flagEvent
);

	logic [PINS-1:0] active;
	logic [PINS-1:0] activePrev_reg;
	logic [PINS-1:0] edgeHit;
	logic levelHold;
	logic setFlag;
	logic flagNext;

	// polarity: one means high level or rising edge
	assign active = ~(pinLevel ^ polaritySelect);
	// [R08] only selected pins count
	assign edgeHit = active & ~activePrev_reg & sourceSelect;
	// [R07] level term only in combined mode
	assign levelHold = detectMode && |(active & sourceSelect);
	// [R19] edge term sets once per active transition; level term sets every cycle
	assign setFlag = |edgeHit || levelHold;
	// [R18] ack blocked while a level persists
	// [R05] ack write clears, set wins
	assign flagNext = setFlag || (pinIrqFlag && !ackWrite);
	assign flagEvent = setFlag && !pinIrqFlag;

	// [R04] flag set only by detection
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			activePrev_reg <= '0;
			pinIrqFlag <= 1'b0;
		end else begin
			activePrev_reg <= active;
			pinIrqFlag <= flagNext;
		end
	end

endmodule

// [rtl/gpx_port.sv]
// two-port gpio with pin interrupt unit behind an axi4-lite slave
// assumes one clock; pins arrive asynchronous, port a direction from
// the neighbouring port a logic on clk_sys
//
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "gpx_params.svh"

// How it works
// [R01] drive bit set means high drive
// [R02] drive select ignored on input pins
// [R03] drive bit five ignores writes
// [R04] flag set by detection, writes ignored
// [R05] ack write clears flag, reads zero
// [R06] enable gates request from flag
// [R07] mode: edges only or edges and levels
// [R08] unselected pins never set the flag
// [R09] polarity picks edge sense and pull
// [R10] pull-down only with interrupt configured
// [R11] data reads pin or latch by direction
// [R12] writes always latch; outputs drive latch
// [R13] reset: data zero, inputs, pulls off
// [R14] direction enables driver, selects read source
// [R15] pull bit switches pull device
// [R16] outputs keep pulls disabled
// [R17] slew bit limits output slew only
// [R18] ack fails while active level remains
// [R19] pins synchronised before edge detection
module gpx_port
	import gpx_pkg::*;
#(
	parameter int DRIVE_W = `GPX_DRIVE_W,
	parameter int IRQ_PINS = `GPX_IRQ_PINS,
	parameter int PORTB_W = `GPX_PORTB_W
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire gpx_pkg::gpx_word_t s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output gpx_pkg::gpx_resp_t s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output gpx_pkg::gpx_word_t s_axi_rdata,
	output gpx_pkg::gpx_resp_t s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// first port
	input wire logic [DRIVE_W-1:0] portaOutputEnable,
	input wire logic [IRQ_PINS-1:0] portaPinIn,
	output logic [DRIVE_W-1:0] portaDriveHigh,
	output logic [IRQ_PINS-1:0] portaPullDown,
	// second port pins
	input wire logic [PORTB_W-1:0] portbPinIn,
	output logic [PORTB_W-1:0] portbPinOut,
	output logic [PORTB_W-1:0] portbPinOe,
	output logic [PORTB_W-1:0] portbPullEnable,
	output logic [PORTB_W-1:0] portbSlewLimit,
	// interrupts
	output logic portIrqRequest,
	output logic irqOut
);

	import gpx_pkg::*;

	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	// registers are one byte wide in the low lane
	if (DRIVE_W > 8 || IRQ_PINS > 8 || PORTB_W > 8 || DRIVE_W < 1 || IRQ_PINS < 1 || PORTB_W < 1) begin
		$error("gpx_port: widths must be 1 to 8");
	end

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic awHeld_reg, awHeld_next;
	logic wHeld_reg, wHeld_next;
	logic [7:0] awAddr_reg;
	gpx_word_t wData_reg;
	logic wLane0_reg;
	logic bValid_next;
	logic rValid_next;
	logic awTake, wTake, arTake, doWrite;
	logic wrLane;
	gpx_resp_t bResp_next;

	logic [DRIVE_W-1:0] drive_reg;
	logic irqEnable_reg;
	logic detectMode_reg;
	logic [IRQ_PINS-1:0] srcSel_reg;
	logic [IRQ_PINS-1:0] polSel_reg;
	logic [PORTB_W-1:0] bData_reg;
	logic [PORTB_W-1:0] bDir_reg;
	logic [PORTB_W-1:0] bPull_reg;
	logic [PORTB_W-1:0] bSlew_reg;
	logic [`GPX_EVT_W-1:0] status_reg, status_next;
	logic [`GPX_EVT_W-1:0] mask_reg;
	logic [`GPX_EVT_W-1:0] eventVec;

	logic [IRQ_PINS-1:0] aPinSync;
	logic [PORTB_W-1:0] bPinSync;
	logic [PORTB_W-1:0] bReadVal;
	logic pinIrqFlag, flagEvent, ackWrite;

	logic wrDrive, wrCtrl, wrSrc, wrPol;
	logic wrBData, wrBDir, wrBPull, wrBSlew, wrStatus, wrMask;
	logic wrMapped;
	logic [7:0] rdAddr;
	logic rdMapped;
	gpx_word_t rdMux;
	logic [7:0] ctrlRead;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	// [R19] pins pass two flops first
	gpx_sync #(.WIDTH(IRQ_PINS)) u_sync_a (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.async(portaPinIn),
		.synced(aPinSync)
	);

	gpx_sync #(.WIDTH(PORTB_W)) u_sync_b (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.async(portbPinIn),
		.synced(bPinSync)
	);

	// ----------------------------------------
	// axi write channel handshakes
	// ----------------------------------------
	// aw and w are held independently so either may come first
	assign awTake = s_axi_awvalid && s_axi_awready;
	assign wTake = s_axi_wvalid && s_axi_wready;
	assign doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;
	assign awHeld_next = !doWrite && (awHeld_reg || awTake);
	assign wHeld_next = !doWrite && (wHeld_reg || wTake);
	assign bValid_next = doWrite || (s_axi_bvalid && !s_axi_bready);
	assign bResp_next = wrMapped ? GPX_RESP_OKAY : GPX_RESP_SLVERR;

	// write address and data capture
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			awAddr_reg <= `GPX_RST_BYTE;
			wData_reg <= `GPX_RST_WORD;
			wLane0_reg <= 1'b0;
		end else begin
			if (awTake) begin
				awAddr_reg <= {s_axi_awaddr[7:2], 2'h0};
			end
			if (wTake) begin
				wData_reg <= s_axi_wdata;
				wLane0_reg <= s_axi_wstrb[0];
			end
		end
	end

	// write handshake state; ready drops while a word is held
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			awHeld_reg <= 1'b0;
			wHeld_reg <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= GPX_RESP_OKAY;
		end else begin
			awHeld_reg <= awHeld_next;
			wHeld_reg <= wHeld_next;
			s_axi_awready <= !awHeld_next && !bValid_next;
			s_axi_wready <= !wHeld_next && !bValid_next;
			s_axi_bvalid <= bValid_next;
			if (doWrite) begin
				s_axi_bresp <= bResp_next;
			end
		end
	end

	// ----------------------------------------
	// write decode
	// ----------------------------------------
	// only byte lane 0 carries register bits
	assign wrLane = doWrite && wLane0_reg;
	assign wrDrive = wrLane && awAddr_reg == `GPX_OFS_DRIVE;
	assign wrCtrl = wrLane && awAddr_reg == `GPX_OFS_IRQCTRL;
	assign wrSrc = wrLane && awAddr_reg == `GPX_OFS_SRCSEL;
	assign wrPol = wrLane && awAddr_reg == `GPX_OFS_POLSEL;
	assign wrBData = wrLane && awAddr_reg == `GPX_OFS_BDATA;
	assign wrBDir = wrLane && awAddr_reg == `GPX_OFS_BDIR;
	assign wrBPull = wrLane && awAddr_reg == `GPX_OFS_BPULL;
	assign wrBSlew = wrLane && awAddr_reg == `GPX_OFS_BSLEW;
	assign wrStatus = wrLane && awAddr_reg == `GPX_OFS_STATUS;
	assign wrMask = wrLane && awAddr_reg == `GPX_OFS_MASK;
	assign wrMapped = awAddr_reg <= `GPX_OFS_MASK;
	// [R05] acknowledge is a write strobe, not stored
	assign ackWrite = wrCtrl && wData_reg[`GPX_CTRL_ACK];

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	// [R03] bit five has no flop, so writes vanish
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			drive_reg <= '0;
			irqEnable_reg <= 1'b0;
			detectMode_reg <= 1'b0;
			srcSel_reg <= '0;
			polSel_reg <= '0;
		end else begin
			if (wrDrive) drive_reg <= wData_reg[DRIVE_W-1:0];
			if (wrCtrl) irqEnable_reg <= wData_reg[`GPX_CTRL_EN];
			if (wrCtrl) detectMode_reg <= wData_reg[`GPX_CTRL_MODE];
			if (wrSrc) srcSel_reg <= wData_reg[IRQ_PINS-1:0];
			if (wrPol) polSel_reg <= wData_reg[IRQ_PINS-1:0];
		end
	end

	// [R13] reset: data zero, all inputs, pulls off
	// [R12] data latches whatever the direction
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			bData_reg <= '0;
			bDir_reg <= '0;
			bPull_reg <= '0;
			bSlew_reg <= '0;
		end else begin
			if (wrBData) bData_reg <= wData_reg[PORTB_W-1:0];
			if (wrBDir) bDir_reg <= wData_reg[PORTB_W-1:0];
			if (wrBPull) bPull_reg <= wData_reg[PORTB_W-1:0];
			if (wrBSlew) bSlew_reg <= wData_reg[PORTB_W-1:0];
		end
	end

	// ----------------------------------------
	// pin interrupt unit
	// ----------------------------------------
	// [R07] mode and [R08] selects feed the detector
	gpx_pin_irq #(.PINS(IRQ_PINS)) u_pin_irq (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.pinLevel(aPinSync),
		.sourceSelect(srcSel_reg),
		.polaritySelect(polSel_reg),
		.detectMode(detectMode_reg),
		.ackWrite(ackWrite),
		.pinIrqFlag(pinIrqFlag),
		.flagEvent(flagEvent)
	);

	// ----------------------------------------
	// sticky status and mask
	// ----------------------------------------
	// [R06] only enabled flags raise an event
	assign eventVec[`GPX_EVT_PINIRQ] = flagEvent && irqEnable_reg;
	// set beats a same-cycle write-one clear
	assign status_next = eventVec | (status_reg & ~(wrStatus ? wData_reg[`GPX_EVT_W-1:0] : '0));

	// status and mask update
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			status_reg <= '0;
			mask_reg <= '0;
		end else begin
			status_reg <= status_next;
			if (wrMask) mask_reg <= wData_reg[`GPX_EVT_W-1:0];
		end
	end

	// ----------------------------------------
	// pin outputs, all registered
	// ----------------------------------------
	// outputs lag the registers by one clock, except irqOut, which is built from status_next; pins see no glitches
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			portaDriveHigh <= '0;
			portaPullDown <= '0;
			portbPinOut <= '0;
			portbPinOe <= '0;
			portbPullEnable <= '0;
			portbSlewLimit <= '0;
			portIrqRequest <= 1'b0;
			irqOut <= 1'b0;
		end else begin
			// [R01] [R02] high drive only where driving
			portaDriveHigh <= drive_reg & portaOutputEnable;
			// [R09] [R10] pull-down needs polarity and select
			portaPullDown <= polSel_reg & srcSel_reg;
			// [R12] [R14] latch driven where output
			portbPinOut <= bData_reg;
			portbPinOe <= bDir_reg;
			// [R15] [R16] pulls only on inputs
			portbPullEnable <= bPull_reg & ~bDir_reg;
			// [R17] slew limit only on outputs
			portbSlewLimit <= bSlew_reg & bDir_reg;
			// [R06] request follows flag when enabled
			portIrqRequest <= pinIrqFlag && irqEnable_reg;
			irqOut <= |(status_next & mask_reg);
		end
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	// [R11] [R14] per bit: latch when output, pin when input
	assign bReadVal = (bData_reg & bDir_reg) | (bPinSync & ~bDir_reg);
	// [R04] [R05] flag visible, ack reads zero
	assign ctrlRead = {4'h0, pinIrqFlag, 1'b0, irqEnable_reg, detectMode_reg};
	assign rdAddr = {s_axi_araddr[7:2], 2'h0};
	assign rdMapped = rdAddr <= `GPX_OFS_MASK;
	// [R03] unused drive bits read zero
	assign rdMux =
		(rdAddr == `GPX_OFS_DRIVE) ? 32'(drive_reg) :
		(rdAddr == `GPX_OFS_IRQCTRL) ? 32'(ctrlRead) :
		(rdAddr == `GPX_OFS_SRCSEL) ? 32'(srcSel_reg) :
		(rdAddr == `GPX_OFS_POLSEL) ? 32'(polSel_reg) :
		(rdAddr == `GPX_OFS_BDATA) ? 32'(bReadVal) :
		(rdAddr == `GPX_OFS_BDIR) ? 32'(bDir_reg) :
		(rdAddr == `GPX_OFS_BPULL) ? 32'(bPull_reg) :
		(rdAddr == `GPX_OFS_BSLEW) ? 32'(bSlew_reg) :
		(rdAddr == `GPX_OFS_STATUS) ? 32'(status_reg) :
		(rdAddr == `GPX_OFS_MASK) ? 32'(mask_reg) : `GPX_RST_WORD;

	assign arTake = s_axi_arvalid && s_axi_arready;
	assign rValid_next = arTake || (s_axi_rvalid && !s_axi_rready);

	// read answer is sampled at the address handshake
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= `GPX_RST_WORD;
			s_axi_rresp <= GPX_RESP_OKAY;
		end else begin
			s_axi_arready <= !rValid_next;
			s_axi_rvalid <= rValid_next;
			if (arTake) begin
				s_axi_rdata <= rdMux;
				s_axi_rresp <= rdMapped ? GPX_RESP_OKAY : GPX_RESP_SLVERR;
			end
		end
	end

endmodule

// [tb/gpx_port_sva.sv]
// checker for the two-port gpio block, watching its ports only
// assumes one clock clk_sys and async active-low nrst
`timescale 1ns/1ps
`include "gpx_params.svh"
module gpx_port_sva
	import gpx_pkg::*;
#(
	parameter int DRIVE_W = `GPX_DRIVE_W,
	parameter int PORTB_W = `GPX_PORTB_W
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// bus read side
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire gpx_pkg::gpx_word_t s_axi_rdata,
	input wire gpx_pkg::gpx_resp_t s_axi_rresp,
	input wire logic s_axi_rvalid,
	// pins and request
	input wire logic [DRIVE_W-1:0] portaOutputEnable,
	input wire logic [DRIVE_W-1:0] portaDriveHigh,
	input wire logic [PORTB_W-1:0] portbPinOut,
	input wire logic [PORTB_W-1:0] portbPinOe,
	input wire logic [PORTB_W-1:0] portbPullEnable,
	input wire logic [PORTB_W-1:0] portbSlewLimit,
	input wire logic portIrqRequest
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// read address taken this edge
	wire rdTake = s_axi_arvalid && s_axi_arready;

	property p_drive_in;
		1 |=> (portaDriveHigh & ~$past(portaOutputEnable)) == '0;
	endproperty
	a_drive_in: assert property (p_drive_in) else $error("drive high on input pin");
	property p_pull_out;
		(portbPullEnable & portbPinOe) == '0;
	endproperty
	a_pull_out: assert property (p_pull_out) else $error("pull on output pin");
	property p_slew_in;
		(portbSlewLimit & ~portbPinOe) == '0;
	endproperty
	a_slew_in: assert property (p_slew_in) else $error("slew on input pin");
	property p_reset_idle;
		$rose(nrst) |-> portbPinOe == '0 && portbPinOut == '0 && portbPullEnable == '0;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("pins not idle after reset");
	property p_ack_zero;
		rdTake && s_axi_araddr == `GPX_OFS_IRQCTRL |=> !s_axi_rdata[`GPX_CTRL_ACK];
	endproperty
	a_ack_zero: assert property (p_ack_zero) else $error("ack bit read as one");
	property p_drive_rsvd;
		rdTake && s_axi_araddr == `GPX_OFS_DRIVE |=> s_axi_rdata[31:DRIVE_W] == '0;
	endproperty
	a_drive_rsvd: assert property (p_drive_rsvd) else $error("unused drive bits set");
	property p_read_out;
		rdTake && s_axi_araddr == `GPX_OFS_BDATA |=> ((s_axi_rdata[7:0] ^ portbPinOut) & portbPinOe) == '0;
	endproperty
	a_read_out: assert property (p_read_out) else $error("output pin read not latch");
	property p_req_gate;
		rdTake && s_axi_araddr == `GPX_OFS_IRQCTRL |=>
			portIrqRequest == (s_axi_rdata[`GPX_CTRL_FLAG] && s_axi_rdata[`GPX_CTRL_EN]);
	endproperty
	a_req_gate: assert property (p_req_gate) else $error("request not flag and enable");
	property p_read_answer;
		rdTake |=> s_axi_rvalid;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("read answer late");
	property p_rsp_map;
		rdTake && {s_axi_araddr[7:2], 2'h0} > `GPX_OFS_MASK |=> s_axi_rresp == GPX_RESP_SLVERR && s_axi_rdata == '0;
	endproperty
	a_rsp_map: assert property (p_rsp_map) else $error("unmapped read not refused");
endmodule

bind gpx_port gpx_port_sva #(.DRIVE_W(DRIVE_W), .PORTB_W(PORTB_W)) u_sva (
	.clk_sys(clk_sys), .nrst(nrst), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.portaOutputEnable(portaOutputEnable), .portaDriveHigh(portaDriveHigh),
	.portbPinOut(portbPinOut), .portbPinOe(portbPinOe), .portbPullEnable(portbPullEnable),
	.portbSlewLimit(portbSlewLimit), .portIrqRequest(portIrqRequest));

// [tb/gpx_pin_model.sv]
// external pin model for the second port
// assumes the bench never drives a pin the block drives
`timescale 1ns/1ps
module gpx_pin_model (
	// clock
	input wire logic clk_sys,
	// block side
	input wire logic [7:0] pinOut,
	input wire logic [7:0] pinOe,
	input wire logic [7:0] pullEn,
	// bench side
	input wire logic [7:0] extEn,
	input wire logic [7:0] extLevel,
	// level seen by the block
	output logic [7:0] pinIn
);
	// floating lines wander each cycle so no stale level passes
	logic [7:0] floatReg = 8'hA5;
	always @(posedge clk_sys) begin
		floatReg <= ~floatReg;
	end
	// pull-up only: this port has no interrupt
	assign pinIn = (pinOe & pinOut) | (~pinOe & extEn & extLevel)
		| (~pinOe & ~extEn & (pullEn | floatReg));
endmodule

// [tb/gpx_port_bench.sv]
// bench for the two-port gpio block over axi4-lite
// assumes gpx_pin_model on the second port pins
`timescale 1ns/1ps
`include "gpx_params.svh"
module gpx_port_bench;
	import gpx_pkg::*;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	// second port pins held low from outside, so reset reads are defined
	logic [7:0] awAddr = 8'h00, arAddr = 8'h00, extEn = 8'hFF, extLvl = 8'h00;
	logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
	gpx_word_t wData = 32'h0;
	logic [4:0] aOe = 5'h00;
	logic [3:0] aPin = 4'h1;
	logic [3:0] wStrb = 4'hF;
	logic awReady, wReady, bValid, arReady, rValid, irqReq, irqOut;
	gpx_resp_t bResp, rResp;
	gpx_word_t rData;
	logic [4:0] driveHigh;
	logic [3:0] pullDown;
	logic [7:0] bIn, bOut, bOe, bPull, bSlew;
	int failCount = 0;
	int totalChecks = 0;

	// ----------------------------------------
	// clock, block and pins
	// ----------------------------------------
	initial begin
		forever #2.5 clk_sys = ~clk_sys;
	end
	gpx_port u_dut (.clk_sys(clk_sys), .nrst(nrst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
		.s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
		.s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
		.s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
		.s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .portaOutputEnable(aOe),
		.portaPinIn(aPin), .portaDriveHigh(driveHigh), .portaPullDown(pullDown), .portbPinIn(bIn),
		.portbPinOut(bOut), .portbPinOe(bOe), .portbPullEnable(bPull), .portbSlewLimit(bSlew),
		.portIrqRequest(irqReq), .irqOut(irqOut));
	gpx_pin_model u_pins (.clk_sys(clk_sys), .pinOut(bOut), .pinOe(bOe), .pullEn(bPull),
		.extEn(extEn), .extLevel(extLvl), .pinIn(bIn));

	// ----------------------------------------
	// report and compare
	// ----------------------------------------
	task giveVerdict;
		$display("checks %0d mismatches %0d", totalChecks, failCount);
		if (failCount == 0 && totalChecks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		totalChecks++;
		if (got !== exp) begin
			failCount++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task hang;
		failCount++;
		$display("unexpected at %0t: bus answer missing", $time);
		giveVerdict();
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// ----------------------------------------
	// bus tasks: valid held until its own ready
	// ----------------------------------------
	task wr(input logic [7:0] a, input logic [7:0] d, input gpx_resp_t er = GPX_RESP_OKAY);
		int n;
		logic done;
		@(posedge clk_sys);
		awAddr <= a;
		wData <= {24'h0, d};
		awValid <= 1'b1;
		wValid <= 1'b1;
		bReady <= 1'b1;
		n = 0;
		done = 1'b0;
		while (!done) begin
			@(posedge clk_sys);
			if (awValid && awReady) awValid <= 1'b0;
			if (wValid && wReady) wValid <= 1'b0;
			if (bValid) begin
				chk(bResp, er, "write answer");
				bReady <= 1'b0;
				done = 1'b1;
			end
			n++;
			if (n > 50) hang();
		end
	endtask
	// read one word and compare data and answer
	task chkRd(input logic [7:0] a, input logic [7:0] exp, input gpx_resp_t er = GPX_RESP_OKAY);
		int n;
		logic done;
		@(posedge clk_sys);
		arAddr <= a;
		arValid <= 1'b1;
		rReady <= 1'b1;
		n = 0;
		done = 1'b0;
		while (!done) begin
			@(posedge clk_sys);
			if (arValid && arReady) arValid <= 1'b0;
			if (rValid) begin
				chk(rData, {24'h0, exp}, "read data");
				chk(rResp, er, "read answer");
				rReady <= 1'b0;
				done = 1'b1;
			end
			n++;
			if (n > 50) hang();
		end
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		tick(5);
		nrst <= 1'b1;
		chk(bOe, 8'h00, "dir after reset");
		chk(bOut, 8'h00, "data after reset");
		for (int i = 0; i <= 36; i += 4) chkRd(i[7:0], 8'h00);
		chkRd(8'h28, 8'h00, GPX_RESP_SLVERR);
		wr(8'h28, 8'hFF, GPX_RESP_SLVERR);
		$display("test reset done");
		// drive strength follows output enable only
		aOe <= 5'h15;
		wr(`GPX_OFS_DRIVE, 8'h3F);
		tick(2);
		chk(driveHigh, 5'h15, "drive");
		chkRd(`GPX_OFS_DRIVE, 8'h1F);
		aOe <= 5'h0A;
		tick(2);
		chk(driveHigh, 5'h0A, "drive input");
		$display("test drive done");
		// second port: latch, direction, pull, slew
		extLvl <= 8'h3C;
		extEn <= 8'hFF;
		wr(`GPX_OFS_BDATA, 8'hA5);
		tick(2);
		chk(bOut, 8'hA5, "latch");
		chkRd(`GPX_OFS_BDATA, 8'h3C);
		extEn <= 8'hF0;
		wr(`GPX_OFS_BDIR, 8'h0F);
		tick(3);
		chk(bOe, 8'h0F, "direction");
		chkRd(`GPX_OFS_BDATA, 8'h35);
		wr(`GPX_OFS_BPULL, 8'hFF);
		wr(`GPX_OFS_BSLEW, 8'hFF);
		tick(2);
		chk(bPull, 8'hF0, "pull");
		chk(bSlew, 8'h0F, "slew");
		// lane 0 strobe low: write answered but ignored
		wStrb <= 4'h0;
		wr(`GPX_OFS_BSLEW, 8'h00);
		wStrb <= 4'hF;
		chkRd(`GPX_OFS_BSLEW, 8'hFF);
		wr(`GPX_OFS_BPULL, 8'h00);
		tick(2);
		chk(bPull, 8'h00, "pull off");
		$display("test port b done");
		// pin 0 falling active, pin 1 rising, pin 2 unselected
		wr(`GPX_OFS_POLSEL, 8'h06);
		wr(`GPX_OFS_SRCSEL, 8'h03);
		wr(`GPX_OFS_IRQCTRL, 8'h06);
		tick(2);
		chk(pullDown, 4'h2, "pull down");
		aPin <= 4'h5;
		tick(6);
		chkRd(`GPX_OFS_IRQCTRL, 8'h02);
		aPin <= 4'h7;
		tick(6);
		chkRd(`GPX_OFS_IRQCTRL, 8'h0A);
		chk(irqReq, 1, "request");
		chkRd(`GPX_OFS_STATUS, 8'h01);
		chk(irqOut, 0, "masked irq");
		wr(`GPX_OFS_MASK, 8'h01);
		tick(2);
		chk(irqOut, 1, "irq");
		wr(`GPX_OFS_STATUS, 8'h01);
		tick(2);
		chk(irqOut, 0, "irq cleared");
		wr(`GPX_OFS_IRQCTRL, 8'h02);
		chkRd(`GPX_OFS_IRQCTRL, 8'h0A);
		wr(`GPX_OFS_IRQCTRL, 8'h06);
		chkRd(`GPX_OFS_IRQCTRL, 8'h02);
		tick(6);
		chkRd(`GPX_OFS_IRQCTRL, 8'h02);
		wr(`GPX_OFS_IRQCTRL, 8'h00);
		aPin <= 4'h5;
		tick(6);
		aPin <= 4'h7;
		tick(6);
		chkRd(`GPX_OFS_IRQCTRL, 8'h08);
		chk(irqReq, 0, "gated request");
		wr(`GPX_OFS_IRQCTRL, 8'h04);
		chkRd(`GPX_OFS_IRQCTRL, 8'h00);
		$display("test edge mode done");
		// level mode: ack refused while a pin stays active
		wr(`GPX_OFS_IRQCTRL, 8'h03);
		tick(6);
		chkRd(`GPX_OFS_IRQCTRL, 8'h0B);
		wr(`GPX_OFS_IRQCTRL, 8'h07);
		chkRd(`GPX_OFS_IRQCTRL, 8'h0B);
		aPin <= 4'h5;
		tick(6);
		wr(`GPX_OFS_IRQCTRL, 8'h07);
		chkRd(`GPX_OFS_IRQCTRL, 8'h03);
		aPin <= 4'h4;
		tick(6);
		chkRd(`GPX_OFS_IRQCTRL, 8'h0B);
		$display("test level mode done");
		giveVerdict();
	end
endmodule
